// ---- src/sacr_top.sv ----
module sacr_top
	import sacr_pkg::*;
#(
	parameter int WAKE_COUNT = sacr_pkg::WAKE_CYCLES,
	parameter int CFG_REGS   = 16
) (
	// Clock and reset
	input  wire logic                                 clock_in,
	input  wire logic                                 srst_in,
	input  wire logic                                 ce_in,
	// Conversion
	input  wire logic                                 conversion_start_in,
	input  wire logic                                 power_down_pin_in,
	input  wire logic [sacr_pkg::CHANNELS*sacr_pkg::RESULT_BITS-1:0] sample_in,
	output logic                                      busy_out,
	output logic                                      ready_out,
	// Readout
	input  wire logic                                 lvds_mode_in,
	input  wire logic                                 readout_cs_n_in,
	input  wire logic                                 readout_clock_in,
	output logic      [sacr_pkg::CHANNELS-1:0]        result_lane_out,
	output logic                                      serial_result_out,
	output logic                                      result_oe_out,
	output logic                                      echo_clock_out,
	// Configuration port
	input  wire logic                                 three_wire_in,
	input  wire logic                                 cfg_cs_n_in,
	input  wire logic                                 cfg_serial_clock_in,
	input  wire logic                                 cfg_data_io_in,
	output logic                                      cfg_data_io_out,
	output logic                                      cfg_data_io_oe_out,
	output logic                                      cfg_data_out,
	output logic                                      cfg_data_oe_out
);
	import sacr_pkg::*;

	initial
	begin
		if (WAKE_COUNT < 1 || CFG_REGS < 1 || CFG_REGS > 2 ** CMD_ADDR_MSB)
			$error("sacr_top: bad parameter");
	end

	localparam int CA = $clog2(CFG_REGS);
	localparam int WC = $clog2(WAKE_COUNT + 1);
	localparam int CB = $clog2(CONV_CYCLES + 1);
	localparam int RB = RESULT_BITS;
	localparam int SB = $clog2(CHANNELS * RESULT_BITS + 1);

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic [8:0] raw_pins;
	logic [8:0] pins;
	assign raw_pins = {conversion_start_in, power_down_pin_in, readout_cs_n_in, readout_clock_in,
		cfg_cs_n_in, cfg_serial_clock_in, cfg_data_io_in, lvds_mode_in, three_wire_in};

	sacr_sync #(.WIDTH(9)) u_sync (
		.clock_in (clock_in),
		.srst_in  (srst_in),
		.ce_in    (ce_in),
		.async_in (raw_pins),
		.sync_out (pins)
	);

	sacr_serial_t rd_s;
	sacr_serial_t cf_s;
	logic         start_s;
	logic         pd_s;
	logic         lvds_s;
	logic         tw_s;
	assign start_s = pins[8];
	assign pd_s    = pins[7];
	assign rd_s    = '{cs_n: pins[6], sck: pins[5], data: 1'b0};
	assign cf_s    = '{cs_n: pins[4], sck: pins[3], data: pins[2]};
	assign lvds_s  = pins[1];
	assign tw_s    = pins[0];

	// Edge history
	logic start_d;
	logic rck_d;
	logic cck_d;
	logic ccs_d;
	always_ff @(posedge clock_in)
	begin
		if (srst_in)
		begin
			start_d <= 1'b0;
			rck_d   <= 1'b0;
			cck_d   <= 1'b0;
			ccs_d   <= 1'b1;
		end
		else if (ce_in)
		begin
			start_d <= start_s;
			rck_d   <= rd_s.sck;
			cck_d   <= cf_s.sck;
			ccs_d   <= cf_s.cs_n;
		end
	end

	wire start_rise = start_s & ~start_d;
	wire rck_rise   = rd_s.sck & ~rck_d;
	wire rck_fall   = ~rd_s.sck & rck_d;
	wire cck_rise   = cf_s.sck & ~cck_d;
	wire cck_fall   = ~cf_s.sck & cck_d;
	wire ccs_fall   = ~cf_s.cs_n & ccs_d;

	// ****************************************************************
	// Wake and conversion
	// ****************************************************************
	typedef enum logic [1:0] {SACR_SLEEP, SACR_WAKE, SACR_IDLE, SACR_CONV} sacr_state_t;
	sacr_state_t state;
	logic [WC-1:0] wake_cnt;
	logic [CB-1:0] conv_cnt;
	logic [CHANNELS*RB-1:0] held;

	wire wake_done = (wake_cnt == WC'(WAKE_COUNT - 1));
	wire conv_done = (conv_cnt == CB'(CONV_CYCLES - 1));

	always_ff @(posedge clock_in)
	begin
		if (srst_in)
		begin
			state     <= SACR_WAKE;
			wake_cnt  <= '0;
			conv_cnt  <= '0;
			busy_out  <= 1'b0;
			ready_out <= 1'b0;
			held      <= '0;
		end
		else if (ce_in)
		begin
			if (pd_s)
			begin
				state     <= SACR_SLEEP;
				busy_out  <= 1'b0;
				ready_out <= 1'b0;
				wake_cnt  <= '0;
			end
			else
			begin
				case (state)
					SACR_SLEEP:
						state <= SACR_WAKE;
					SACR_WAKE:
					begin
						wake_cnt <= wake_cnt + 1'b1;
						if (wake_done)
						begin
							state     <= SACR_IDLE;
							ready_out <= 1'b1;
						end
					end
					SACR_IDLE:
						if (start_rise)
						begin
							held     <= sample_in;
							busy_out <= 1'b1;
							conv_cnt <= '0;
							state    <= SACR_CONV;
						end
					SACR_CONV:
					begin
						conv_cnt <= conv_cnt + 1'b1;
						if (conv_done)
						begin
							busy_out <= 1'b0;
							state    <= SACR_IDLE;
						end
					end
					default:
						state <= SACR_WAKE;
				endcase
			end
		end
	end

	wire load_results = ce_in & ~pd_s & (state == SACR_CONV) & conv_done;

	// ****************************************************************
	// Result readout
	// ****************************************************************
	logic [CHANNELS*RB-1:0] shift;
	logic [SB-1:0]          bits_left;
	wire rd_active = ~rd_s.cs_n;
	wire rd_step   = rd_active & (lvds_s ? (rck_rise | rck_fall) : rck_rise);

	always_ff @(posedge clock_in)
	begin
		if (srst_in)
		begin
			shift             <= '0;
			bits_left         <= '0;
			result_lane_out   <= '0;
			serial_result_out <= 1'b0;
			result_oe_out     <= 1'b0;
			echo_clock_out    <= 1'b0;
		end
		else if (ce_in)
		begin
			result_oe_out  <= rd_active;
			echo_clock_out <= rd_active & rd_s.sck;
			if (load_results)
			begin
				shift     <= held;
				bits_left <= SB'(CHANNELS * RB);
			end
			else if (rd_step && bits_left != '0)
			begin
				for (int c = 0; c < CHANNELS; c++)
					result_lane_out[c] <= shift[c*RB + RB - 1];
				serial_result_out <= shift[CHANNELS*RB - 1];
				shift     <= {shift[CHANNELS*RB-2:0], 1'b0};
				bits_left <= bits_left - 1'b1;
			end
		end
	end

	// ****************************************************************
	// Configuration port
	// ****************************************************************
	logic [CFG_BITS-1:0] regs [CFG_REGS];
	logic [CFG_CMD_BITS-1:0] cmd;
	logic [5:0]              ccount;
	logic [CFG_BITS-1:0]     cfg_shift;
	logic                    cfg_drive;

	wire cfg_sel   = ~cf_s.cs_n;
	wire is_read   = cmd[CMD_READ_BIT];
	wire [CA-1:0] addr = cmd[CA-1:0];
	wire cmd_full  = (ccount == 6'(CFG_CMD_BITS));
	wire data_full = (ccount == 6'(CFG_CMD_BITS + CFG_BITS - 1));

	always_ff @(posedge clock_in)
	begin
		if (srst_in)
		begin
			cmd                <= '0;
			ccount             <= '0;
			cfg_shift          <= '0;
			cfg_drive          <= 1'b0;
			cfg_data_io_out    <= 1'b0;
			cfg_data_io_oe_out <= 1'b0;
			cfg_data_out       <= 1'b0;
			cfg_data_oe_out    <= 1'b0;
			for (int i = 0; i < CFG_REGS; i++)
				regs[i] <= '0;
		end
		else if (ce_in)
		begin
			if (!cfg_sel)
			begin
				ccount             <= '0;
				cfg_drive          <= 1'b0;
				cfg_data_io_oe_out <= 1'b0;
				cfg_data_oe_out    <= 1'b0;
			end
			else
			begin
				if (ccs_fall && !tw_s)
					cfg_data_oe_out <= 1'b1;
				if (cck_rise)
				begin
					if (ccount < 6'(CFG_CMD_BITS))
					begin
						cmd    <= {cmd[CFG_CMD_BITS-2:0], cf_s.data};
						ccount <= ccount + 1'b1;
					end
					else if (!is_read)
					begin
						cfg_shift <= {cfg_shift[CFG_BITS-2:0], cf_s.data};
						ccount    <= ccount + 1'b1;
						if (data_full)
							regs[addr] <= {cfg_shift[CFG_BITS-2:0], cf_s.data};
					end
				end
				if (cmd_full && is_read && !cfg_drive)
				begin
					cfg_drive <= 1'b1;
					cfg_shift <= regs[addr];
					if (tw_s)
						cfg_data_io_oe_out <= 1'b1;
				end
				if (cck_fall && cfg_drive)
				begin
					cfg_data_io_out <= cfg_shift[CFG_BITS-1];
					cfg_data_out    <= cfg_shift[CFG_BITS-1];
					cfg_shift       <= {cfg_shift[CFG_BITS-2:0], 1'b0};
				end
			end
		end
	end

endmodule

// ---- src/sacr_pkg.sv ----
package sacr_pkg;

	// ****************************************************************
	// Geometry
	// ****************************************************************
	localparam int CHANNELS    = 8;
	localparam int RESULT_BITS = 16;
	localparam int CFG_BITS    = 16;
	localparam int CFG_CMD_BITS = 16;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_PS   = 25000;
	localparam int CONV_TIME_NS    = 665;
	localparam int CONV_CYCLES     = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
	localparam int WAKE_TIME_MS    = 1;
	localparam int WAKE_CYCLES     = (WAKE_TIME_MS * 1000000000) / CLK_PERIOD_PS;
	localparam int CYC_TIME_NS     = 4000;
	localparam int CYC_CYCLES      = (CYC_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ****************************************************************
	// Command word fields
	// ****************************************************************
	localparam int CMD_READ_BIT = 15;
	localparam int CMD_ADDR_MSB = 14;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic cs_n;
		logic sck;
		logic data;
	} sacr_serial_t;

	typedef struct packed {
		logic data;
		logic oe;
	} sacr_drive_t;

endpackage

// ---- src/sacr_sync.sv ----
module sacr_sync #(
	parameter int WIDTH = 1
) (
	// Clock
	input  wire logic             clock_in,
	input  wire logic             srst_in,
	input  wire logic             ce_in,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge clock_in)
	begin
		if (srst_in)
		begin
			stage1   <= '0;
			sync_out <= '0;
		end
		else if (ce_in)
		begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

// ---- tb/sacr_properties.sv ----
module sacr_properties (
	// ********
	// Watched ports
	// ********
	input wire logic clock_in,
	input wire logic srst_in,
	input wire logic ce_in,
	input wire logic conversion_start_in,
	input wire logic power_down_pin_in,
	input wire logic busy_out,
	input wire logic ready_out,
	input wire logic lvds_mode_in,
	input wire logic readout_cs_n_in,
	input wire logic result_oe_out,
	input wire logic serial_result_out,
	input wire logic echo_clock_out,
	input wire logic three_wire_in,
	input wire logic cfg_cs_n_in,
	input wire logic cfg_data_io_oe_out,
	input wire logic cfg_data_oe_out
);
	default clocking @(posedge clock_in);
	endclocking
	default disable iff (srst_in || !ce_in);
	a_busy_starts: assert property ($rose(conversion_start_in) && ready_out && !busy_out && !power_down_pin_in
		|-> ##[1:4] busy_out) else $error("busy late");
	a_busy_length: assert property ($rose(busy_out) |-> busy_out[*8] ##18 busy_out ##1 !busy_out)
		else $error("busy length");
	a_wake_first: assert property ($rose(busy_out) |-> $past(ready_out)) else $error("start in wake");
	a_cfg_enable: assert property ($fell(cfg_cs_n_in) && !three_wire_in |-> ##[1:4] cfg_data_oe_out)
		else $error("no drive");
	a_cfg_release: assert property ($rose(cfg_cs_n_in) |-> ##[1:4] !cfg_data_oe_out && !cfg_data_io_oe_out)
		else $error("cfg held");
	a_result_release: assert property ($rose(readout_cs_n_in) |-> ##[1:4] !result_oe_out) else $error("readout held");
	a_io_cause: assert property ($rose(cfg_data_io_oe_out) |-> three_wire_in && !cfg_cs_n_in) else $error("io drive");
	a_echo_track: assert property (lvds_mode_in && !readout_cs_n_in && !$past(readout_cs_n_in, 4) && !$fell(busy_out)
		&& $changed(serial_result_out) |-> $changed(echo_clock_out)) else $error("echo lost");
endmodule

bind sacr_top sacr_properties u_sacr_properties (.clock_in, .srst_in, .ce_in, .conversion_start_in, .power_down_pin_in,
	.busy_out, .ready_out, .lvds_mode_in, .readout_cs_n_in, .result_oe_out, .serial_result_out, .echo_clock_out,
	.three_wire_in, .cfg_cs_n_in, .cfg_data_io_oe_out, .cfg_data_oe_out);

// ---- tb/sacr_host.sv ----
module sacr_host (
	// ********
	// Host pins
	// ********
	input  wire logic clock_in,
	output logic      start_out,
	output logic      cs_n_out,
	output logic      sck_out
);
	timeunit 1ns;
	timeprecision 1ps;
	realtime last = -1;
	initial
	begin
		start_out = 0;
		cs_n_out = 1;
		sck_out = 0;
	end
	task automatic convert();
		@(posedge clock_in);
		while (last >= 0 && $realtime - last < 4000)
			@(posedge clock_in);
		#1 start_out = 1;
		last = $realtime;
		repeat (4) @(posedge clock_in);
		#1 start_out = 0;
	endtask
	task automatic select(input logic on);
		cs_n_out = !on;
		#100;
	endtask
	task automatic toggle();
		sck_out = !sck_out;
		#100;
	endtask
endmodule

// ---- tb/sacr_tb_top.sv ----
module sacr_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ********
	// Harness
	// ********
	logic clock_in = 0, srst_in = 1, ce = 1, pd = 0, lvds = 0, three = 0, ccs_n = 1, cfg_serial_clock = 0, hio = 0;
	logic [127:0] smp = '0;
	logic start, rcs_n, rsck, busy, ready, oe, echo, ser, io_o, io_oe, cdo, cdo_oe;
	logic [7:0] lane;
	wire io = io_oe ? io_o : hio;
	int failures = 0, checked = 0;
	localparam logic [127:0] P = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
	always #12.5 clock_in = ~clock_in;
	sacr_host host (.clock_in, .start_out(start), .cs_n_out(rcs_n), .sck_out(rsck));
	sacr_top #(.WAKE_COUNT(20)) dut (.clock_in, .srst_in, .ce_in(ce), .conversion_start_in(start),
		.power_down_pin_in(pd), .sample_in(smp), .busy_out(busy), .ready_out(ready), .lvds_mode_in(lvds),
		.readout_cs_n_in(rcs_n), .readout_clock_in(rsck), .result_lane_out(lane), .serial_result_out(ser),
		.result_oe_out(oe), .echo_clock_out(echo), .three_wire_in(three), .cfg_cs_n_in(ccs_n),
		.cfg_serial_clock_in(cfg_serial_clock), .cfg_data_io_in(io), .cfg_data_io_out(io_o), .cfg_data_io_oe_out(io_oe),
		.cfg_data_out(cdo), .cfg_data_oe_out(cdo_oe));
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	task automatic wait_for(ref logic s, input logic v);
		for (int n = 0; n < 400; n++)
		begin
			if (s === v)
				return;
			tick(1);
		end
		failures++;
		$display("ERROR %0t timeout", $time);
		results();
	endtask
	task automatic t_wake();
		pd = 1;
		tick(4);
		pd = 0;
		host.convert();
		tick(8);
		check(busy, 0);
		wait_for(ready, 1);
		check(ready, 1);
		$display("wake done");
	endtask
	task automatic t_freeze();
		smp = P;
		host.convert();
		wait_for(busy, 1);
		ce = 0;
		tick(40);
		check(busy, 1);
		ce = 1;
		wait_for(busy, 0);
		check(busy, 0);
		$display("freeze done");
	endtask
	task automatic t_cmos(input logic [127:0] v);
		logic [7:0] e;
		smp = v;
		host.convert();
		wait_for(busy, 1);
		wait_for(busy, 0);
		host.select(1);
		for (int i = 0; i < 16; i++)
		begin
			for (int c = 0; c < 8; c++)
				e[c] = v[16 * c + 15 - i];
			host.toggle();
			check(lane, e);
			check(echo, 1);
			host.toggle();
		end
		host.select(0);
		$display("cmos done");
	endtask
	task automatic t_lvds(input logic [127:0] v);
		smp = v;
		lvds = 1;
		host.convert();
		wait_for(busy, 1);
		wait_for(busy, 0);
		host.select(1);
		for (int i = 0; i < 32; i++)
		begin
			host.toggle();
			check(ser, v[127 - i]);
		end
		host.select(0);
		lvds = 0;
		$display("lvds done");
	endtask
	task automatic cfg_frame(input logic [31:0] w, output logic [15:0] rd);
		tick(1);
		ccs_n = 0;
		#100;
		for (int k = 0; k < 32; k++)
		begin
			hio = (k > 15 && w[31]) ? ~hio : w[31 - k];
			#100;
			if (k > 15)
				rd[31 - k] = three ? io : cdo;
			if (k == 16 && three && w[31])
				check(io_oe, 1);
			cfg_serial_clock = 1;
			#100 cfg_serial_clock = 0;
		end
		#100 ccs_n = 1;
		#200;
		check(io_oe | cdo_oe, 0);
	endtask
	task automatic t_cfg(input logic t);
		logic [15:0] r;
		three = t;
		cfg_frame({16'h0005, 16'hA5C3 ^ {16{t}}}, r);
		cfg_frame({16'h8005, 16'h0000}, r);
		check(r, 16'hA5C3 ^ {16{t}});
		$display("cfg done");
	endtask
	initial
	begin
		tick(12);
		srst_in = 0;
		t_wake();
		t_freeze();
		t_cmos(P);
		t_cmos(~P);
		t_lvds({P[63:0], P[127:64]});
		t_cfg(0);
		t_cfg(1);
		results();
	end
endmodule
